// [pkg/dmic_pkg.sv]
/*
  Shared constants for the digital microphone record path: register
  indices, field positions, pin function codes and filter types.
  Assumes a 32-bit AXI4-Lite register bus, one 8-bit register per word.
*/
`default_nettype none

package dmic_pkg;
  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam int IDX_W = 7;
  localparam logic [IDX_W-1:0] REG_PAGE = 7'h00;
  localparam logic [IDX_W-1:0] REG_OSR = 7'h14;
  localparam logic [IDX_W-1:0] REG_WLEN = 7'h1b;
  localparam logic [IDX_W-1:0] REG_STATUS = 7'h24;
  localparam logic [IDX_W-1:0] REG_CLKPIN = 7'h33;
  localparam logic [IDX_W-1:0] REG_DATAPIN = 7'h34;
  localparam logic [IDX_W-1:0] REG_PRB = 7'h3d;
  localparam logic [IDX_W-1:0] REG_EDGE = 7'h50;
  localparam logic [IDX_W-1:0] REG_DMIC_EN = 7'h51;
  localparam logic [IDX_W-1:0] REG_LVOL = 7'h53;
  localparam logic [IDX_W-1:0] REG_RVOL = 7'h54;
  localparam logic [7:0] PAGE_MAIN = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_OSR = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Fields
  // ****************************************
  localparam int FN_LSB = 2;
  localparam int FN_MSB = 5;
  localparam logic [3:0] FN_MODCLK = 4'h1;
  localparam logic [3:0] FN_DATAIN = 4'h2;
  localparam int EDGE_L_BIT = 1;
  localparam int EDGE_R_BIT = 0;
  localparam int EN_L_BIT = 1;
  localparam int EN_R_BIT = 0;
  localparam logic [7:0] OSR_128 = 8'h80;
  localparam logic [7:0] OSR_64 = 8'h40;
  localparam logic [7:0] OSR_32 = 8'h20;
  localparam logic [2:0] LOG_128 = 3'd7;
  localparam logic [2:0] LOG_64 = 3'd6;
  localparam logic [2:0] LOG_32 = 3'd5;
  localparam logic [7:0] PRB_B_FIRST = 8'h07;
  localparam logic [7:0] PRB_C_FIRST = 8'h0d;
  localparam logic [1:0] WLEN_16 = 2'd0;
  localparam logic [1:0] WLEN_20 = 2'd1;
  localparam logic [1:0] WLEN_24 = 2'd2;
  localparam int VOL_FRAC = 6;
  localparam logic signed [8:0] VOL_UNITY = 9'sh040;
  localparam logic signed [31:0] WORD_MAX = 32'sh7fff_ffff;
  localparam logic signed [31:0] WORD_MIN = 32'sh8000_0000;

  typedef enum logic [2:0] {
    FILT_A = 3'b001,
    FILT_B = 3'b010,
    FILT_C = 3'b100
  } filt_type;
endpackage : dmic_pkg

`default_nettype wire

// [testbench/dmic_mic_model.sv]
/*
  Behavioural digital microphone: one-bit output at a level set by the bench.
  Assumes the bench resolves both pins and hands in the clock it sees.
*/
`default_nettype none

module dmic_mic_model (
  input wire logic aclk,
  input wire logic mclk,
  input wire logic run,
  input wire logic lvl,
  input wire logic lvl_f,
  output logic dat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bit_ff;
  logic idle_ff = 1'b0;
  // ****************
  // Bit output
  // ****************
  // New bit on every clock edge: set after a fall for the rising-edge catch,
  // after a rise for the falling-edge catch, so the edge choice is visible
  always @(mclk) begin
    bit_ff = mclk ? lvl_f : lvl;
  end
  // Released line flips each cycle so no stale bit can pass
  always_ff @(posedge aclk) begin
    idle_ff <= ~idle_ff;
  end
  assign dat = run ? bit_ff : idle_ff;
endmodule : dmic_mic_model

`default_nettype wire

// [testbench/tb_top.sv]
/*
  Register-call bench for the microphone record path.
  Assumes the design and microphone model are compiled before it.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dmic_pkg::*;
  localparam int MH = 4;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, lvl = 1, lvl_f = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, lw, rw, v;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, cpi, cpo, cpoe;
  logic dpi, dpo, dpoe, wclk, wv, offl, offr, mdat;
  int bad_count = 0, num_checks = 0;
  logic [6:0] ri [7] = '{REG_PAGE, REG_CLKPIN, REG_DATAPIN, REG_EDGE, REG_LVOL,
                         REG_RVOL, REG_OSR};
  // Pin levels: the design drives where enabled, else the microphone
  assign cpi = !cpoe ? cpo : mdat;
  assign dpi = !dpoe ? dpo : mdat;

  dmic_record_path #(.MOD_HALF(MH)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mic_clock_pin_in(cpi),
    .mic_clock_pin_out(cpo), .mic_clock_pin_oe_n(cpoe), .mic_data_pin_in(dpi),
    .mic_data_pin_out(dpo), .mic_data_pin_oe_n(dpoe), .word_clk_ff(wclk),
    .word_valid_ff(wv), .left_word_ff(lw), .right_word_ff(rw),
    .analog_off_left(offl), .analog_off_right(offr));

  dmic_mic_model i_mic (.aclk(aclk), .mclk((!cpoe && cpo) || (!dpoe && dpo)),
    .run(!cpoe || !dpoe), .lvl(lvl), .lvl_f(lvl_f), .dat(mdat));

  // ****************
  // Clock, verdict, watchdog
  // ****************
  initial begin
    forever #25 aclk = ~aclk;
  end
  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // Longest run is about 30k cycles; double it
  initial begin
    #(60000 * 50);
    bad_count++;
    close_out();
  end

  // ****************
  // Bus and compare tasks
  // ****************
  function automatic logic [11:0] ba(input logic [6:0] idx);
    return {3'b000, idx, 2'b00};
  endfunction : ba
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // Handshakes are sampled at the rising edge, before the design updates
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [6:0] idx, input logic [31:0] e);
    rd(ba(idx));
    chk("register", e, v);
  endtask : rchk
  // Cycles from one word pulse to the next, bounded
  task automatic frame(output int n, output int hi);
    n = 0;
    hi = 0;
    do begin
      @(negedge aclk);
      n++;
      if (wclk === 1'b1) hi++;
    end while (wv !== 1'b1 && n < 9000);
  endtask : frame
  // Five frames let the fourth-order filter settle after a change
  task automatic stream(input int per, input logic [31:0] le, input logic [31:0] re);
    int n;
    int hi;
    repeat (5) frame(n, hi);
    chk("frame spacing", per, n);
    chk("word clock high", per / 2, hi);
    chk("left word", le, lw);
    chk("right word", re, rw);
  endtask : stream

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rchk(ri[i], (i == 6) ? RESET_OSR : RESET_BYTE);
    end
    chk("pins released", 2'b11, {cpoe, dpoe});
    wr(ba(REG_LVOL), 32'h0000_01a5);
    chk("write response", RESP_OKAY, resp);
    rchk(REG_LVOL, 32'h0000_00a5);
    rchk(7'h10, 32'h0000_0000);
    rd(12'h800);
    chk("read response", RESP_SLVERR, resp);
    wr(12'h800, 32'h0000_0001);
    chk("write response", RESP_SLVERR, resp);
    wr(ba(REG_PAGE), 32'h0000_0001);
    wr(ba(REG_LVOL), 32'h0000_0033);
    rchk(REG_PAGE, 32'h0000_0001);
    rchk(REG_LVOL, 32'h0000_0000);
    wr(ba(REG_PAGE), 32'h0000_0000);
    rchk(REG_LVOL, 32'h0000_00a5);
    wr(ba(REG_LVOL), 32'h0000_0000);
    wr(ba(REG_CLKPIN), 32'h0000_0004);
    wr(ba(REG_DATAPIN), 32'h0000_0008);
    wr(ba(REG_DMIC_EN), 32'h0000_0003);
    chk("pin drive", 2'b01, {cpoe, dpoe});
    chk("analog off", 2'b11, {offl, offr});
    rchk(REG_STATUS, {27'h0, FILT_A, 2'b11});
    stream(128 * 2 * MH, 32'h7fff_0000, 32'h7fff_0000);
    wr(ba(REG_OSR), 32'h0000_0040);
    stream(64 * 2 * MH, 32'h7fff_0000, 32'h7fff_0000);
    wr(ba(REG_PRB), 32'h0000_0007);
    rchk(REG_STATUS, {27'h0, FILT_B, 2'b11});
    stream(64 * 2 * MH, 32'h7fff_0000, 32'h7fff_0000);
    wr(ba(REG_PRB), 32'h0000_000d);
    rchk(REG_STATUS, {27'h0, FILT_C, 2'b11});
    stream(32 * 2 * MH, 32'h7fff_0000, 32'h7fff_0000);
    wr(ba(REG_PRB), 32'h0000_0000);
    wr(ba(REG_OSR), 32'h0000_0080);
    wr(ba(REG_EDGE), 32'h0000_0002);
    wr(ba(REG_RVOL), 32'h0000_00c0);
    lvl_f <= 1'b0;
    stream(128 * 2 * MH, 32'h8000_0000, 32'h0000_0000);
    wr(ba(REG_RVOL), 32'h0000_0000);
    wr(ba(REG_DMIC_EN), 32'h0000_0002);
    lvl <= 1'b0;
    chk("analog off", 2'b10, {offl, offr});
    stream(128 * 2 * MH, 32'h8000_0000, 32'h0000_0000);
    wr(ba(REG_DMIC_EN), 32'h0000_0003);
    wr(ba(REG_CLKPIN), 32'h0000_0008);
    wr(ba(REG_DATAPIN), 32'h0000_0004);
    wr(ba(REG_WLEN), 32'h0000_0003);
    lvl <= 1'b1;
    lvl_f <= 1'b1;
    chk("pin drive", 2'b10, {cpoe, dpoe});
    stream(128 * 2 * MH, 32'h7fff_ffff, 32'h7fff_ffff);
    close_out();
  end
endmodule : tb_top

`default_nettype wire

// [verilog/cic_decimator.sv]
/*
  Fourth-order CIC decimator for one microphone channel.
  Assumes bit_valid pulses once per modulator period and dump pulses once
  per frame; the comb section runs only at dump.
*/
`default_nettype none

module cic_decimator #(
  parameter int ORDER = 4,
  parameter int W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic dump,
  input wire logic [2:0] ratio_log,
  output logic [W-1:0] sample_ff,
  output logic valid_ff
);
  // ****************************************
  // Integrators and combs
  // ****************************************
  logic [W-1:0] acc_ff [ORDER];
  logic [W-1:0] dly_ff [ORDER];
  logic [W-1:0] comb [ORDER+1];
  logic [W-1:0] full;
  logic [5:0] shift;

  // Modular arithmetic: wrap in the integrators cancels in the combs
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      for (int i = 0; i < ORDER; i++) acc_ff[i] <= '0;
    end else if (bit_valid) begin
      acc_ff[0] <= acc_ff[0] + (bit_in ? W'(1) : {W{1'b1}});
      for (int i = 1; i < ORDER; i++) acc_ff[i] <= acc_ff[i] + acc_ff[i-1];
    end
  end

  // Comb chain evaluated at the frame boundary
  always_comb begin
    comb[0] = acc_ff[ORDER-1];
    for (int i = 0; i < ORDER; i++) comb[i+1] = comb[i] - dly_ff[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      for (int i = 0; i < ORDER; i++) dly_ff[i] <= '0;
    end else if (dump) begin
      for (int i = 0; i < ORDER; i++) dly_ff[i] <= comb[i];
    end
  end

  // Full scale is 2**(ORDER*log R); scale it up to the word's top bit
  assign shift = 6'(W - 1) - 6'(ORDER * ratio_log);
  assign full = W'(1) << 6'(ORDER * ratio_log);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= dump;
      if (dump) begin
        if (!enable) sample_ff <= '0;
        else if (comb[ORDER] == full) sample_ff <= {1'b0, {(W-1){1'b1}}};
        else sample_ff <= comb[ORDER] << shift;
      end
    end
  end
endmodule : cic_decimator

`default_nettype wire

// [verilog/dmic_record_path.sv]
/*
  Digital microphone record path: register file on AXI4-Lite with page
  selection, modulator clock generation, pin muxing, edge-selected bit
  capture, CIC decimation, volume, and rounding of the per-frame word pair.
  Assumes the microphone answers on the pin set as data input and that
  software programs a decimation ratio suited to the microphone.
*/
`default_nettype none

module dmic_record_path
  import dmic_pkg::*;
#(
  parameter int MOD_HALF = 3,
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mic_clock_pin_in,
  output logic mic_clock_pin_out,
  output logic mic_clock_pin_oe_n,
  input wire logic mic_data_pin_in,
  output logic mic_data_pin_out,
  output logic mic_data_pin_oe_n,
  output logic word_clk_ff,
  output logic word_valid_ff,
  output logic [31:0] left_word_ff,
  output logic [31:0] right_word_ff,
  output logic analog_off_left,
  output logic analog_off_right
);
  import dmic_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] page_ff, osr_ff, wlen_ff, clkpin_ff, datapin_ff;
  logic [7:0] prb_ff, edge_ff, en_ff, lvol_ff, rvol_ff;
  logic [IDX_W-1:0] widx, ridx;
  logic wr_take, rd_take, wr_bad, rd_bad, in_main;
  logic [7:0] rd_byte, status;

  // Address and data are taken together, one write in flight at a time
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_take = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign widx = s_axi_awaddr[IDX_W+1:2];
  assign ridx = s_axi_araddr[IDX_W+1:2];
  assign wr_bad = |s_axi_awaddr[ADDR_W-1:IDX_W+2];
  assign rd_bad = |s_axi_araddr[ADDR_W-1:IDX_W+2];
  assign in_main = (page_ff == PAGE_MAIN);

  // Page pointer is reachable from every page
  always_ff @(posedge aclk) begin
    if (!aresetn) page_ff <= PAGE_MAIN;
    else if (wr_take && !wr_bad && s_axi_wstrb[0] && widx == REG_PAGE)
      page_ff <= s_axi_wdata[7:0];
  end

  // Page-0 controls; writes in any other page leave them untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osr_ff <= RESET_OSR;
      wlen_ff <= RESET_BYTE;
      clkpin_ff <= RESET_BYTE;
      datapin_ff <= RESET_BYTE;
      prb_ff <= RESET_BYTE;
      edge_ff <= RESET_BYTE;
      en_ff <= RESET_BYTE;
      lvol_ff <= RESET_BYTE;
      rvol_ff <= RESET_BYTE;
    end else if (wr_take && !wr_bad && s_axi_wstrb[0] && in_main) begin
      case (widx)
        REG_OSR: osr_ff <= s_axi_wdata[7:0];
        REG_WLEN: wlen_ff <= s_axi_wdata[7:0];
        REG_CLKPIN: clkpin_ff <= s_axi_wdata[7:0];
        REG_DATAPIN: datapin_ff <= s_axi_wdata[7:0];
        REG_PRB: prb_ff <= s_axi_wdata[7:0];
        REG_EDGE: edge_ff <= s_axi_wdata[7:0];
        REG_DMIC_EN: en_ff <= s_axi_wdata[7:0];
        REG_LVOL: lvol_ff <= s_axi_wdata[7:0];
        REG_RVOL: rvol_ff <= s_axi_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Write response; out-of-range addresses get SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux: 8-bit registers sit in the low byte, upper bits read zero
  always_comb begin
    rd_byte = RESET_BYTE;
    if (ridx == REG_PAGE) rd_byte = page_ff;
    else if (in_main) begin
      case (ridx)
        REG_OSR: rd_byte = osr_ff;
        REG_WLEN: rd_byte = wlen_ff;
        REG_STATUS: rd_byte = status;
        REG_CLKPIN: rd_byte = clkpin_ff;
        REG_DATAPIN: rd_byte = datapin_ff;
        REG_PRB: rd_byte = prb_ff;
        REG_EDGE: rd_byte = edge_ff;
        REG_DMIC_EN: rd_byte = en_ff;
        REG_LVOL: rd_byte = lvol_ff;
        REG_RVOL: rd_byte = rvol_ff;
        default: rd_byte = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_bad ? '0 : {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Filter type and ratio
  // ****************************************
  filt_type ftype;
  logic [2:0] ratio_log;

  // Type is never written directly; it follows the processing block
  always_comb begin
    if (prb_ff >= PRB_C_FIRST) ftype = FILT_C;
    else if (prb_ff >= PRB_B_FIRST) ftype = FILT_B;
    else ftype = FILT_A;
  end

  // Each type accepts only its own ratios; anything else falls back
  always_comb begin
    case (ftype)
      FILT_A: ratio_log = (osr_ff == OSR_64) ? LOG_64 : LOG_128;
      FILT_B: ratio_log = LOG_64;
      FILT_C: ratio_log = LOG_32;
      default: ratio_log = LOG_128;
    endcase
  end

  assign status = {3'b000, ftype, en_ff[EN_L_BIT], en_ff[EN_R_BIT]};

  // ****************************************
  // Modulator clock and pins
  // ****************************************
  logic [7:0] half_cnt_ff;
  logic mod_clk_ff, mod_rise, mod_fall, half_done;
  logic [3:0] clk_fn, data_fn;
  logic clk_s1_ff, clk_s2_ff, dat_s1_ff, dat_s2_ff, mic_bit;

  assign half_done = (half_cnt_ff == 8'(MOD_HALF - 1));
  assign mod_rise = half_done && !mod_clk_ff;
  assign mod_fall = half_done && mod_clk_ff;

  // Divider keeps the modulator clock free-running from reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt_ff <= '0;
      mod_clk_ff <= 1'b0;
    end else if (half_done) begin
      half_cnt_ff <= '0;
      mod_clk_ff <= !mod_clk_ff;
    end else begin
      half_cnt_ff <= half_cnt_ff + 8'd1;
    end
  end

  assign clk_fn = clkpin_ff[FN_MSB:FN_LSB];
  assign data_fn = datapin_ff[FN_MSB:FN_LSB];
  assign mic_clock_pin_out = mod_clk_ff;
  assign mic_data_pin_out = mod_clk_ff;
  assign mic_clock_pin_oe_n = (clk_fn != FN_MODCLK);
  assign mic_data_pin_oe_n = (data_fn != FN_MODCLK);

  // Pin inputs cross into aclk through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      dat_s1_ff <= 1'b0;
      dat_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= mic_clock_pin_in;
      clk_s2_ff <= clk_s1_ff;
      dat_s1_ff <= mic_data_pin_in;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // Data pin wins when both are set as input
  assign mic_bit = (data_fn == FN_DATAIN) ? dat_s2_ff :
                   (clk_fn == FN_DATAIN) ? clk_s2_ff : 1'b0;

  // ****************************************
  // Bit capture and decimation
  // ****************************************
  logic take_l, take_r, en_l, en_r, frame_pulse;
  logic [7:0] bit_cnt_ff;
  logic [31:0] dec_l, dec_r;
  logic dec_valid;

  assign en_l = en_ff[EN_L_BIT];
  assign en_r = en_ff[EN_R_BIT];
  assign analog_off_left = en_l;
  assign analog_off_right = en_r;
  // Synced bit lags the pin by two cycles: it is the value held before the edge
  assign take_l = en_l && (edge_ff[EDGE_L_BIT] ? mod_fall : mod_rise);
  assign take_r = en_r && (edge_ff[EDGE_R_BIT] ? mod_fall : mod_rise);

  // Frame every 2**ratio_log modulator periods
  assign frame_pulse = mod_rise && (bit_cnt_ff == 8'((1 << ratio_log) - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) bit_cnt_ff <= '0;
    else if (frame_pulse) bit_cnt_ff <= '0;
    else if (mod_rise) bit_cnt_ff <= bit_cnt_ff + 8'd1;
  end

  // Word clock: high for the first half of each frame
  always_ff @(posedge aclk) begin
    if (!aresetn) word_clk_ff <= 1'b0;
    else if (frame_pulse) word_clk_ff <= 1'b1;
    else if (mod_rise && bit_cnt_ff == 8'((1 << ratio_log) >> 1) - 8'd1)
      word_clk_ff <= 1'b0;
  end

  cic_decimator u_cic_left (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(en_l),
    .bit_valid(take_l),
    .bit_in(mic_bit),
    .dump(frame_pulse),
    .ratio_log(ratio_log),
    .sample_ff(dec_l),
    .valid_ff(dec_valid)
  );

  cic_decimator u_cic_right (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(en_r),
    .bit_valid(take_r),
    .bit_in(mic_bit),
    .dump(frame_pulse),
    .ratio_log(ratio_log),
    .sample_ff(dec_r),
    .valid_ff()
  );

  // ****************************************
  // Volume and rounding
  // ****************************************
  logic [31:0] vol_l_ff, vol_r_ff;
  logic vol_valid_ff;

  // Gain = (64 + signed volume) / 64, saturated to 32 bits
  function automatic logic [31:0] scale(input logic [31:0] x, input logic [7:0] v);
    logic signed [40:0] prod;
    logic signed [40:0] sh;
    prod = $signed(x) * (VOL_UNITY + $signed({v[7], v}));
    sh = prod >>> VOL_FRAC;
    if (sh > 41'(WORD_MAX)) return WORD_MAX;
    else if (sh < 41'(WORD_MIN)) return WORD_MIN;
    else return sh[31:0];
  endfunction : scale

  // Round half up at the interface width, clamp, clear dropped bits
  function automatic logic [31:0] round_word(input logic [31:0] x, input logic [1:0] wl);
    logic [4:0] drop;
    logic signed [32:0] sum;
    logic [31:0] mask;
    drop = (wl == WLEN_16) ? 5'd16 : (wl == WLEN_20) ? 5'd12 :
           (wl == WLEN_24) ? 5'd8 : 5'd0;
    if (drop == 5'd0) return x;
    mask = 32'hffff_ffff << drop;
    sum = $signed({x[31], x}) + $signed(33'(33'h0_0000_0001 << (drop - 5'd1)));
    if (sum[32] != sum[31]) return WORD_MAX & mask;
    return sum[31:0] & mask;
  endfunction : round_word

  // Volume stage; the processing stage passes the word through unchanged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vol_l_ff <= '0;
      vol_r_ff <= '0;
      vol_valid_ff <= 1'b0;
    end else begin
      vol_valid_ff <= dec_valid;
      if (dec_valid) begin
        vol_l_ff <= scale(dec_l, lvol_ff);
        vol_r_ff <= scale(dec_r, rvol_ff);
      end
    end
  end

  // Pair handed to the serial side once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_word_ff <= '0;
      right_word_ff <= '0;
      word_valid_ff <= 1'b0;
    end else begin
      word_valid_ff <= vol_valid_ff;
      if (vol_valid_ff) begin
        left_word_ff <= round_word(vol_l_ff, wlen_ff[1:0]);
        right_word_ff <= round_word(vol_r_ff, wlen_ff[1:0]);
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence frame_s;
    frame_pulse;
  endsequence
  sequence pair_out_s;
    ##3 word_valid_ff;
  endsequence

  chk_pair_per_frame: assert property (frame_s |-> pair_out_s)
    else $error("word pair missing three cycles after frame");
  chk_page_select: assert property (wr_take && !wr_bad && s_axi_wstrb[0]
      && widx == REG_PAGE |=> page_ff == $past(s_axi_wdata[7:0]))
    else $error("page register not loaded");
  chk_page_gates_write: assert property (wr_take && !in_main
      && widx == REG_LVOL |=> $stable(lvol_ff))
    else $error("write leaked outside selected page");
  chk_modclk_pin_out: assert property (clk_fn == FN_MODCLK && half_done
      |-> !mic_clock_pin_oe_n ##1 mic_clock_pin_out != $past(mic_clock_pin_out))
    else $error("modulator clock not on clock pin");
  chk_left_edge_sel: assert property (take_l
      |=> mic_clock_pin_out != $past(edge_ff[EDGE_L_BIT]))
    else $error("left bit taken on wrong edge");
  chk_type_c_ratio: assert property (ftype == FILT_C |-> ratio_log == LOG_32)
    else $error("filter C not at ratio 32");
  chk_round_low_bits: assert property (word_valid_ff && wlen_ff[1:0] == WLEN_16
      |-> left_word_ff[15:0] == 16'h0000 && right_word_ff[15:0] == 16'h0000)
    else $error("rounded word has low bits set");
  chk_disabled_zero: assert property (frame_pulse && !en_r
      |-> ##3 right_word_ff == 32'h0000_0000)
    else $error("disabled right channel not silent");
  chk_bresp_follows: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response not raised");
endmodule : dmic_record_path

`default_nettype wire
